// >>> common/fcd_cfg.svh
// Purpose: Constants for the four-channel transfer controller.
// Assumes: 200 MHz system clock.
// Notes: Values here are fixed by the block's behaviour.
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
`define FCD_NUM_CH 4
`define FCD_MARK_PERIOD 8'h80
`define FCD_MODE_VERIFY 2'h0
`define FCD_MODE_WRITE 2'h1
`define FCD_MODE_READ 2'h2
`endif

// >>> common/fcd_pkg.sv
// Purpose: Types for the four-channel transfer controller.
// Assumes: Included together with fcd_cfg.svh.
// Notes: Strobes are active low.
package fcd_pkg;
  typedef enum logic [2:0] {
    FCD_IDLE = 3'b000,
    FCD_HOLD = 3'b001,
    FCD_S1 = 3'b010,
    FCD_S2 = 3'b011,
    FCD_S3 = 3'b100,
    FCD_S4 = 3'b101
  } fcd_state_t;
  typedef struct packed {
    logic memory_read_n;
    logic memory_write_n;
    logic io_read_n;
    logic io_write_n;
  } fcd_strobe_t;
endpackage

// >>> hw/fcd_top.sv
// Purpose: Four-channel transfer controller core with bus hold handshake.
// Assumes: Channel setup arrives on plain ports from same-clock logic.
// Notes: Pins from outside pass two flip-flops before use.
// Notes on behaviour
// - Four channels, each request and acknowledge.
// - Sequential memory address every transfer cycle.
// - Fixed priority, one acknowledge at once.
// - Single hold request, wait for grant.
// - Per-channel cycle counter decremented per cycle.
// - Terminal count when programmed cycles reached.
// - Block-boundary pulse every 128 cycles.
// - Address enable and upper latch strobe out.
// - Keep bus while request held, until count.
// - Low address on pins, high on data.
// - Read and write modes drive strobe pairs.
// - Verify mode drives no strobes.
`timescale 1ns/1ps
`include "fcd_cfg.svh"
module fcd_top
  import fcd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] channel_request_i,
  input wire logic bus_hold_grant_i,
  input wire logic [3:0] cfg_load_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic [13:0] cfg_count_i,
  input wire logic [1:0] cfg_mode_i,
  output logic [3:0] channel_acknowledge_n_o,
  output logic bus_hold_request_o,
  output logic address_drive_enable_o,
  output logic upper_address_latch_strobe_o,
  output logic terminal_count_o,
  output logic block_mark_o,
  output logic [7:0] addr_low_o,
  output logic addr_low_oe_n_o,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output fcd_strobe_t strobe_n_o,
  output logic strobe_oe_n_o
);
  logic [3:0] req_s1_q, req_q;
  logic grant_s1_q, grant_q;
  fcd_state_t state_q;
  logic [1:0] ch_q;
  logic [15:0] addr_q [4];
  logic [13:0] count_q [4];
  logic [1:0] mode_q [4];
  logic [3:0] hit_tc;
  logic [1:0] pick;
  logic any_req;
  logic [15:0] cur_addr;
  logic [3:0] live;
  logic [3:0] done_q;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_s1_q <= 4'h0;
      req_q <= 4'h0;
      grant_s1_q <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      req_s1_q <= channel_request_i;
      req_q <= req_s1_q;
      grant_s1_q <= bus_hold_grant_i;
      grant_q <= grant_s1_q;
    end
  end

  // Fixed priority: channel 0 highest; rotation is left to software setup.
  always_comb begin
    pick = 2'h0;
    live = req_q & ~done_q;
    any_req = |live;
    for (int i = 3; i >= 0; i--) begin
      if (live[i]) begin
        pick = 2'(i);
      end
    end
  end

  assign cur_addr = addr_q[ch_q];

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= FCD_IDLE;
      ch_q <= 2'h0;
    end else begin
      unique case (state_q)
        FCD_IDLE: begin
          if (any_req) begin
            state_q <= FCD_HOLD;
          end
        end
        FCD_HOLD: begin
          if (grant_q) begin
            ch_q <= pick;
            state_q <= FCD_S1;
          end
        end
        FCD_S1: state_q <= FCD_S2;
        FCD_S2: state_q <= FCD_S3;
        FCD_S3: state_q <= FCD_S4;
        FCD_S4: begin
          // Bus is kept while the served request holds and count is not reached.
          if (req_q[ch_q] && !(count_q[ch_q] == 14'h0000) && grant_q) begin
            state_q <= FCD_S1;
          end else if (any_req && grant_q) begin
            ch_q <= pick;
            state_q <= FCD_S1;
          end else begin
            state_q <= FCD_IDLE;
          end
        end
        default: state_q <= FCD_IDLE;
      endcase
    end
  end

  // Counters hold cycles-minus-one so zero marks the final cycle.
  generate
    for (genvar c = 0; c < `FCD_NUM_CH; c++) begin : g_ch
      assign hit_tc[c] = (count_q[c] == 14'h0000);
      always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
          addr_q[c] <= 16'h0000;
          count_q[c] <= 14'h0000;
          mode_q[c] <= `FCD_MODE_VERIFY;
        end else if (cfg_load_i[c]) begin
          addr_q[c] <= cfg_addr_i;
          count_q[c] <= cfg_count_i;
          mode_q[c] <= cfg_mode_i;
        end else if (state_q == FCD_S4 && ch_q == 2'(c)) begin
          addr_q[c] <= addr_q[c] + 16'h0001;
          if (!hit_tc[c]) begin
            count_q[c] <= count_q[c] - 14'h0001;
          end
        end
      end
    end
  endgenerate

  // A finished channel stays out of arbitration until it is loaded again.
  // Without this a request held past terminal count would run further cycles at count zero.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_q <= 4'h0;
    end else begin
      for (int c = 0; c < `FCD_NUM_CH; c++) begin
        if (cfg_load_i[c]) begin
          done_q[c] <= 1'b0;
        end else if (state_q == FCD_S2 && ch_q == 2'(c) && hit_tc[c]) begin
          done_q[c] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_hold_request_o <= 1'b0;
      address_drive_enable_o <= 1'b0;
      upper_address_latch_strobe_o <= 1'b0;
      channel_acknowledge_n_o <= 4'hf;
      addr_low_o <= 8'h00;
      addr_low_oe_n_o <= 1'b1;
      data_o <= 8'h00;
      data_oe_n_o <= 1'b1;
    end else begin
      bus_hold_request_o <= (state_q != FCD_IDLE) || any_req;
      address_drive_enable_o <= (state_q != FCD_IDLE && state_q != FCD_HOLD) ||
                                (state_q == FCD_HOLD && grant_q);
      upper_address_latch_strobe_o <= (state_q == FCD_S1);
      if (state_q == FCD_S1) begin
        addr_low_o <= cur_addr[7:0];
        addr_low_oe_n_o <= 1'b0;
        data_o <= cur_addr[15:8];
        data_oe_n_o <= 1'b0;
      end else if (state_q == FCD_S2) begin
        data_oe_n_o <= 1'b1;
      end else if (state_q == FCD_IDLE || state_q == FCD_HOLD) begin
        addr_low_oe_n_o <= 1'b1;
        data_oe_n_o <= 1'b1;
      end
      channel_acknowledge_n_o <= 4'hf;
      if (state_q == FCD_S2 || state_q == FCD_S3) begin
        channel_acknowledge_n_o[ch_q] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      terminal_count_o <= 1'b0;
      block_mark_o <= 1'b0;
    end else begin
      terminal_count_o <= (state_q == FCD_S2) && hit_tc[ch_q];
      // Low seven count bits track the cycle index within a block.
      block_mark_o <= (state_q == FCD_S2) &&
                      (count_q[ch_q][6:0] == 7'h00) && !hit_tc[ch_q];
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_n_o <= 4'hf;
      strobe_oe_n_o <= 1'b1;
    end else begin
      strobe_n_o <= 4'hf;
      strobe_oe_n_o <= (state_q == FCD_IDLE || state_q == FCD_HOLD);
      if (state_q == FCD_S2 || state_q == FCD_S3) begin
        unique case (mode_q[ch_q])
          `FCD_MODE_READ: begin
            strobe_n_o.memory_read_n <= 1'b0;
            strobe_n_o.io_write_n <= 1'b0;
          end
          `FCD_MODE_WRITE: begin
            strobe_n_o.io_read_n <= 1'b0;
            strobe_n_o.memory_write_n <= 1'b0;
          end
          default: strobe_n_o <= 4'hf;
        endcase
      end
    end
  end
endmodule

// >>> tb/fcd_asserts.sv
// Purpose: Port checks for fcd_top.
// Assumes: One clock domain.
// Notes: Watches outputs only.
`timescale 1ns/1ps
module fcd_asserts
  import fcd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [3:0] channel_acknowledge_n_o,
  input wire logic bus_hold_request_o,
  input wire logic address_drive_enable_o,
  input wire logic upper_address_latch_strobe_o,
  input wire logic terminal_count_o,
  input wire logic block_mark_o,
  input wire logic addr_low_oe_n_o,
  input wire logic data_oe_n_o,
  input wire fcd_strobe_t strobe_n_o,
  input wire logic strobe_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  wire logic ak = ~&channel_acknowledge_n_o;
  sequence s_ack2;
    ak [*2] ##1 !ak;
  endsequence
  a_one_ack: assert property ($onehot0(~channel_acknowledge_n_o))
    else $error("two acks");
  a_bus_owned: assert property (ak |->
    bus_hold_request_o && address_drive_enable_o)
    else $error("ack without bus");
  a_ack_width: assert property ($rose(ak) |-> s_ack2)
    else $error("ack width");
  a_latch_ack: assert property (upper_address_latch_strobe_o |=> $rose(ak))
    else $error("latch not followed by ack");
  a_addr_pair: assert property (upper_address_latch_strobe_o |->
    !data_oe_n_o && !addr_low_oe_n_o)
    else $error("address bytes not driven");
  a_strobe_in_ack: assert property (strobe_n_o != 4'hf |->
    ak && !strobe_oe_n_o)
    else $error("strobe outside ack");
  a_tc_pulse: assert property (terminal_count_o |-> ak ##1 !terminal_count_o)
    else $error("terminal count shape");
  a_mark_alone: assert property (block_mark_o |-> ak && !terminal_count_o)
    else $error("mark shape");
  a_float_idle: assert property (!bus_hold_request_o [*2] |->
    addr_low_oe_n_o && data_oe_n_o && strobe_oe_n_o)
    else $error("drive while idle");
endmodule
bind fcd_top fcd_asserts u_chk (.*);

// >>> tb/fcd_host_model.sv
// Purpose: Host side that grants the bus hold.
// Assumes: Grant follows the hold request.
// Notes: A delay input lets a scenario grant promptly or slowly.
`timescale 1ns/1ps
module fcd_host_model (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic bus_hold_request_i,
  input wire logic [3:0] delay_i,
  output logic bus_hold_grant_o
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 4'h0;
      bus_hold_grant_o <= 1'b0;
    end else if (!bus_hold_request_i) begin
      wait_q <= 4'h0;
      bus_hold_grant_o <= 1'b0;
    end else if (wait_q >= delay_i) begin
      bus_hold_grant_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// >>> tb/test_four_channel_dma_control.sv
// Purpose: Self-checking bench for fcd_top.
// Assumes: Grant comes from fcd_host_model.
// Notes: Short counts keep the run brief.
`timescale 1ns/1ps
module test_four_channel_dma_control;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, bus_hold_grant_i;
  logic [3:0] channel_request_i = 4'h0, cfg_load_i = 4'h0, dly = 4'h0, channel_acknowledge_n_o;
  logic [15:0] cfg_addr_i = 16'h0, cap;
  logic [13:0] cfg_count_i = 14'h0;
  logic [1:0] cfg_mode_i = 2'h0;
  logic bus_hold_request_o, address_drive_enable_o, upper_address_latch_strobe_o;
  logic terminal_count_o, block_mark_o, addr_low_oe_n_o, data_oe_n_o, strobe_oe_n_o;
  logic [7:0] addr_low_o, data_o;
  fcd_pkg::fcd_strobe_t strobe_n_o;
  logic [25:0] q[$], exp, got;
  integer seed = 32'hf0d6940a, n_mismatch = 0, tests_run = 0, i;
  fcd_top DUT (.*);
  fcd_host_model u_host (.clk_sys_i, .nrst_i, .bus_hold_request_i(bus_hold_request_o),
    .delay_i(dly), .bus_hold_grant_o(bus_hold_grant_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  task close_out;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [25:0] g, input logic [25:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bad(input logic b);
    if (b) begin
      n_mismatch++;
      close_out();
    end
  endtask
  // Notes the expected transfers while loading one channel.
  task automatic load(input int c, input logic [1:0] m, input logic [13:0] n);
    logic [15:0] a;
    logic [13:0] k;
    a = $random(seed);
    dly = $random(seed);
    cfg_load_i = 4'h1 << c;
    cfg_addr_i = a;
    cfg_count_i = n;
    cfg_mode_i = m;
    @(negedge clk_sys_i);
    cfg_load_i = 4'h0;
    for (k = 14'h0; k <= n; k++) q.push_back({~(4'h1 << c),
      m == 2'h1 ? 4'h9 : m == 2'h2 ? 4'h6 : 4'hf, k == n,
      k != n && ((n - k) & 14'h7f) == 14'h0, a + 16'(k)});
  endtask
  task automatic go(input logic [3:0] r);
    int t;
    channel_request_i = r;
    for (t = 0; q.size() > 0 && t < 2000; t++) @(negedge clk_sys_i);
    bad(q.size() > 0);
    channel_request_i = 4'h0;
    for (t = 0; bus_hold_request_o !== 1'b0 && t < 40; t++) @(negedge clk_sys_i);
    bad(bus_hold_request_o !== 1'b0);
    $display("test done at %0t", $time);
  endtask
  // The address is captured at the latch strobe, the rest one cycle later with the ack.
  always @(negedge clk_sys_i) if (upper_address_latch_strobe_o === 1'b1) begin
    cap = {data_o, addr_low_o};
    @(negedge clk_sys_i);
    exp = q.size() > 0 ? q.pop_front() : 26'h0;
    got = {channel_acknowledge_n_o, strobe_n_o, terminal_count_o, block_mark_o, cap};
    cmp(got, exp);
  end
  initial begin
    repeat (10) @(negedge clk_sys_i);
    nrst_i = 1'b1;
    for (i = 0; i < 3; i++) begin
      load(i, 2'(i), 14'h2);
      go(4'h1 << i);
    end
    load(1, 2'h2, 14'h1);
    load(3, 2'h1, 14'h1);
    go(4'ha);
    load(2, 2'h3, 14'h81);
    go(4'h4);
    close_out();
  end
endmodule
